/* File: src/can_mailbox_controller.v */
// Summary of operation
// - Bit rate is clock over (prescaler+1) over (3+seg1+seg2) quanta.
// - Format select: standard, extended or per-mailbox mixed identifiers.
// - Thirty-two mailboxes, each usable for transmit or receive.
// - FIFO mode: 24 mailboxes plus four-deep transmit and receive FIFOs.
// - Transmit arbitration by mailbox number or by identifier priority.
// - Cancelled transmit sets abort-complete flag, no cancel interrupt.
// - One-shot transmit never retries after error or lost arbitration.
// - Receive mailbox takes data or remote frames; FIFO may take both.
// - Eight acceptance masks, each shared by four consecutive mailboxes.
// - Full unread mailbox: overwrite or discard, set lost flag; overrun only on discard.
// - One-shot receive mailbox stops receiving after one message.
// - Error-passive interrupt when either error count reaches 128.
// - Bus-off and entry interrupt when transmit count reaches 256.
// - Recovery interrupt after 128 runs of 11 recessive bits, in auto or halt-recovery mode only.
// - One combined warning interrupt when either count reaches 96.
// - Bus-lock interrupt after 32 consecutive dominant bits.
// - Bus errors recorded for software and raise a bus error interrupt.
// - Bus-off recovery follows auto, halt-entry, halt-recovery or manual.
// - Hardware reset enters sleep; leaving sleep goes to reset or halt.
// - Reset mode reinitialises flags, counts, timestamp, FIFOs, error code.
// - 16-bit timestamp ticks every 1, 2, 4 or 8 bit times.
// - Listen-only and external loopback test modes; internal loopback samples canTx, which it holds recessive.
// - Mode field: normal, reset, halt, forced reset without waiting.
// - Prohibited segment codes are raised to the shortest legal setting.
`timescale 1ns/1ns
`include "can_mailbox_regs.vh"

module can_mailbox_controller #(
  parameter ID_W = 29,
  parameter PRE_W = 10
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Mode and configuration
  input wire [1:0] operatingModeSelect,
  input wire sleepRequest,
  input wire txPriorityMode,
  input wire [1:0] idFormatModeSelect,
  input wire fifoMailboxMode,
  input wire overwriteMode,
  input wire [1:0] recoveryMode,
  input wire recoveryCommand,
  input wire [1:0] testMode,
  input wire [1:0] timestampSelect,
  input wire errorCodeClear,
  // Bit timing
  input wire [PRE_W-1:0] prescalerSetting,
  input wire [3:0] phaseSegmentOne,
  input wire [2:0] phaseSegmentTwo,
  // Mailbox setup, a bit or identifier per mailbox, a mask per four
  input wire [31:0] txRequest,
  input wire [31:0] rxRequest,
  input wire [31:0] abortRequest,
  input wire [31:0] oneShot,
  input wire [31:0] remoteRequestSelect,
  input wire [31:0] frameIdLengthFlag,
  input wire [31:0] maskInvalidSelect,
  input wire [31:0] readAck,
  input wire [32*ID_W-1:0] mailboxId,
  input wire [8*ID_W-1:0] acceptanceMask,
  // FIFO access
  input wire fifoIdCompareZeroRtr,
  input wire fifoIdCompareOneRtr,
  input wire txFifoPush,
  input wire [ID_W-1:0] txFifoId,
  input wire txFifoIde,
  input wire rxFifoPop,
  // Frame engine events
  input wire rxFrameValid,
  input wire [ID_W-1:0] rxFrameId,
  input wire rxFrameIde,
  input wire rxFrameRtr,
  input wire txFrameDone,
  input wire txArbLost,
  input wire txBusError,
  input wire rxBusError,
  input wire [2:0] busErrorType,
  input wire txBitIn,
  input wire txBusy,
  // Bus pins
  input wire canRx,
  output reg canTx,
  // Bit engine timing
  output reg sampledBit,
  output reg sampleTick,
  output reg bitTick,
  // Transmit and receive handoff
  output reg txStart,
  output reg [5:0] txSlot,
  output reg [ID_W-1:0] txIdOut,
  output reg txIdeOut,
  output reg rxStore,
  output reg [5:0] rxStoreSlot,
  // Mailbox flags
  output reg [31:0] txPending,
  output reg [31:0] sentData,
  output reg [31:0] abortComplete,
  output reg [31:0] newData,
  output reg [31:0] messageLost,
  // Error state
  output reg [8:0] txErrorCount,
  output reg [7:0] rxErrorCount,
  output reg errorPassive,
  output reg busOff,
  output reg [2:0] errorCodeStore,
  // Interrupt request pulses
  output reg errorWarningIrq,
  output reg errorPassiveIrq,
  output reg busOffEntryIrq,
  output reg busOffRecoveryIrq,
  output reg busLockIrq,
  output reg busErrorIrq,
  output reg rxOverrunIrq,
  output reg txFifoIrq,
  output reg rxFifoIrq,
  // Status
  output reg [15:0] timestamp,
  output reg sleepState,
  output reg resetState,
  output reg haltState,
  output reg [2:0] txFifoCount,
  output reg [2:0] rxFifoCount,
  output reg [ID_W-1:0] rxFifoHeadId
);

  localparam ST_SLEEP = 2'b00;
  localparam ST_RESET = 2'b01;
  localparam ST_HALT = 2'b10;
  localparam ST_NORMAL = 2'b11;

  reg [1:0] state;
  reg rxMeta, rxSync;
  reg [PRE_W-1:0] preCnt;
  reg [4:0] tqCnt;
  reg [2:0] tsDiv;
  reg [3:0] recRun;
  reg [7:0] recRuns;
  reg [5:0] domRun;
  reg txActive;
  reg [31:0] rxArmed;
  reg [31:0] abortWait;
  reg [ID_W:0] txFifoMem [0:3];
  reg [ID_W-1:0] rxFifoMem [0:3];
  reg [1:0] txRd, txWr, rxRd, rxWr;

  // Decoded controls
  wire swReset = (state == ST_RESET);
  wire running = (state == ST_NORMAL);
  wire [4:0] ts1q = {1'b0, (phaseSegmentOne < `TS1_MIN) ?
    `TS1_MIN : phaseSegmentOne} + 5'h01;
  wire [4:0] ts2q = {2'b00, (phaseSegmentTwo < `TS2_MIN) ?
    `TS2_MIN : phaseSegmentTwo} + 5'h01;
  wire tqTick = (state != ST_SLEEP) && (preCnt == prescalerSetting);
  wire busLine = (testMode == `TEST_INT_LOOP) ? canTx : rxSync;
  wire [2:0] selMask = (3'h1 << timestampSelect) - 3'h1;
  wire txSilent = (testMode == `TEST_LISTEN);
  wire [ID_W:0] txHead = txFifoMem[txRd];

  // Per-mailbox identifier length and transmit eligibility
  wire [31:0] mbExt;
  wire [31:0] mbUsable;
  genvar g;

  function [ID_W-1:0] priKey;
    input [ID_W-1:0] id;
    input ext;
    begin
      priKey = ext ? id : {id[ID_W-1:`STD_SHIFT], {`STD_SHIFT{1'b0}}};
    end
  endfunction

  // Transmit arbitration
  reg txFound;
  reg [5:0] txPick;
  reg [ID_W-1:0] txKey;
  reg [ID_W-1:0] curKey;
  integer i;
  integer j;
  always @* begin
    txFound = 1'b0;
    txPick = 6'h00;
    txKey = {ID_W{1'b1}};
    curKey = {ID_W{1'b0}};
    for (i = 0; i < `MB_COUNT; i = i + 1) begin
      curKey = priKey(mailboxId[i*ID_W +: ID_W], mbExt[i]);
      if (txPending[i] && !abortRequest[i] && mbUsable[i] && !abortWait[i] &&
          (!txFound || (!txPriorityMode && curKey < txKey))) begin
        txFound = 1'b1;
        txPick = i[5:0];
        txKey = curKey;
      end
    end
    curKey = priKey(txHead[ID_W-1:0], txHead[ID_W]);
    if (fifoMailboxMode && txFifoCount != 3'h0 &&
        (!txFound || (!txPriorityMode && curKey < txKey))) begin
      txFound = 1'b1;
      txPick = `FIFO_SLOT;
    end
  end

  // Receive acceptance
  reg rxFound;
  reg [5:0] rxPick;
  reg [ID_W-1:0] useMask;
  always @* begin
    rxFound = 1'b0;
    rxPick = 6'h00;
    useMask = {ID_W{1'b0}};
    for (j = 0; j < `MB_COUNT; j = j + 1) begin
      useMask = maskInvalidSelect[j] ? {ID_W{1'b1}} :
        acceptanceMask[(j/4)*ID_W +: ID_W];
      if (!mbExt[j])
        useMask = {useMask[ID_W-1:`STD_SHIFT], {`STD_SHIFT{1'b0}}};
      if (!rxFound && rxArmed[j] && mbUsable[j] &&
          rxFrameIde == mbExt[j] &&
          rxFrameRtr == remoteRequestSelect[j] &&
          ((rxFrameId ^ mailboxId[j*ID_W +: ID_W]) & useMask) ==
            {ID_W{1'b0}}) begin
        rxFound = 1'b1;
        rxPick = j[5:0];
      end
    end
  end

  wire rxEvent = running && rxFrameValid;
  wire fifoTake = rxEvent && !rxFound && fifoMailboxMode &&
    (rxFrameRtr == fifoIdCompareZeroRtr ||
     rxFrameRtr == fifoIdCompareOneRtr);
  wire txFail = txActive && (txArbLost || txBusError);
  wire txOk = txActive && txFrameDone;

  // Mailbox flag logic, set wins over clear throughout
  generate
    for (g = 0; g < `MB_COUNT; g = g + 1) begin : mbox
      wire mine = txActive && (txSlot == g);
      wire rxHit = rxEvent && rxFound && (rxPick == g);
      wire abortNow = (abortRequest[g] && txPending[g] && !mine) ||
        (abortWait[g] && mine && txFail);
      assign mbExt[g] = (idFormatModeSelect == `ID_FORMAT_MODE_SELECT_EXT) ||
        ((idFormatModeSelect == `ID_FORMAT_MODE_SELECT_MIX) && frameIdLengthFlag[g]);
      assign mbUsable[g] = !fifoMailboxMode || (g < `MB_NORMAL);
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          txPending[g] <= 1'b0;
          sentData[g] <= 1'b0;
          abortComplete[g] <= 1'b0;
          abortWait[g] <= 1'b0;
          rxArmed[g] <= 1'b0;
          newData[g] <= 1'b0;
          messageLost[g] <= 1'b0;
        end else if (swReset) begin
          txPending[g] <= 1'b0;
          sentData[g] <= 1'b0;
          abortComplete[g] <= 1'b0;
          abortWait[g] <= 1'b0;
          rxArmed[g] <= 1'b0;
          newData[g] <= 1'b0;
          messageLost[g] <= 1'b0;
        end else begin
          if (txRequest[g])
            txPending[g] <= 1'b1;
          else if ((mine && txOk) || abortNow ||
                   (mine && txFail && oneShot[g]))
            txPending[g] <= 1'b0;
          if (mine && txOk)
            sentData[g] <= 1'b1;
          else if (txRequest[g])
            sentData[g] <= 1'b0;
          if (abortNow)
            abortComplete[g] <= 1'b1;
          else if (txRequest[g])
            abortComplete[g] <= 1'b0;
          if (abortRequest[g] && mine)
            abortWait[g] <= 1'b1;
          else if (!mine)
            abortWait[g] <= 1'b0;
          if (rxRequest[g])
            rxArmed[g] <= 1'b1;
          else if (rxHit && oneShot[g])
            rxArmed[g] <= 1'b0;
          if (rxHit)
            newData[g] <= 1'b1;
          else if (readAck[g])
            newData[g] <= 1'b0;
          if (rxHit && newData[g])
            messageLost[g] <= 1'b1;
          else if (readAck[g])
            messageLost[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // Error counter next values
  reg [8:0] next_tec;
  reg [7:0] next_rec;
  always @* begin
    next_tec = txErrorCount;
    next_rec = rxErrorCount;
    if (txActive && txBusError)
      next_tec = txErrorCount + `TEC_STEP;
    else if (txOk && txErrorCount != 9'h000)
      next_tec = txErrorCount - 9'h001;
    if (rxBusError && rxErrorCount != `REC_MAX)
      next_rec = rxErrorCount + 8'h01;
    else if (rxEvent && rxErrorCount != 8'h00)
      next_rec = rxErrorCount - 8'h01;
  end
  wire nextWarn = (next_tec >= `ERR_WARN) || ({1'b0, next_rec} >= `ERR_WARN);
  wire curWarn = (txErrorCount >= `ERR_WARN) ||
    ({1'b0, rxErrorCount} >= `ERR_WARN);
  wire nextPass = (next_tec >= `ERR_PASSIVE) ||
    ({1'b0, next_rec} >= `ERR_PASSIVE);
  wire recoverDone = busOff && sampleTick && busLine &&
    recRun == `RECESSIVE_RUN - 4'h1 && recRuns == `RECOVERY_RUNS - 8'h01;
  wire autoRecover = recoverDone && (recoveryMode == `RECOV_AUTO ||
    recoveryMode == `RECOV_HALT_END);
  wire manualRecover = busOff && recoveryCommand &&
    recoveryMode != `RECOV_AUTO && recoveryMode != `RECOV_HALT_END;

  // Mode, timing, error state and FIFOs
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= ST_SLEEP;
      rxMeta <= 1'b1;
      rxSync <= 1'b1;
      canTx <= 1'b1;
      preCnt <= {PRE_W{1'b0}};
      tqCnt <= 5'h00;
      sampledBit <= 1'b1;
      sampleTick <= 1'b0;
      bitTick <= 1'b0;
      tsDiv <= 3'h0;
      timestamp <= 16'h0000;
      recRun <= 4'h0;
      recRuns <= 8'h00;
      domRun <= 6'h00;
      txActive <= 1'b0;
      txStart <= 1'b0;
      txSlot <= 6'h00;
      txIdOut <= {ID_W{1'b0}};
      txIdeOut <= 1'b0;
      rxStore <= 1'b0;
      rxStoreSlot <= 6'h00;
      txErrorCount <= 9'h000;
      rxErrorCount <= 8'h00;
      errorPassive <= 1'b0;
      busOff <= 1'b0;
      errorCodeStore <= 3'h0;
      errorWarningIrq <= 1'b0;
      errorPassiveIrq <= 1'b0;
      busOffEntryIrq <= 1'b0;
      busOffRecoveryIrq <= 1'b0;
      busLockIrq <= 1'b0;
      busErrorIrq <= 1'b0;
      rxOverrunIrq <= 1'b0;
      txFifoIrq <= 1'b0;
      rxFifoIrq <= 1'b0;
      sleepState <= 1'b1;
      resetState <= 1'b0;
      haltState <= 1'b0;
      txFifoCount <= 3'h0;
      rxFifoCount <= 3'h0;
      txRd <= 2'h0;
      txWr <= 2'h0;
      rxRd <= 2'h0;
      rxWr <= 2'h0;
      rxFifoHeadId <= {ID_W{1'b0}};
    end else begin
      rxMeta <= canRx;
      rxSync <= rxMeta;
      sleepState <= (state == ST_SLEEP);
      resetState <= (state == ST_RESET);
      haltState <= (state == ST_HALT);
      // Mode transitions
      case (state)
        ST_SLEEP:
          if (!sleepRequest)
            state <= (operatingModeSelect == `MODE_HALT) ?
              ST_HALT : ST_RESET;
        ST_RESET:
          if (sleepRequest)
            state <= ST_SLEEP;
          else if (operatingModeSelect == `MODE_NORMAL)
            state <= ST_NORMAL;
          else if (operatingModeSelect == `MODE_HALT)
            state <= ST_HALT;
        ST_HALT:
          if (sleepRequest)
            state <= ST_SLEEP;
          else if (operatingModeSelect == `MODE_NORMAL)
            state <= ST_NORMAL;
          else if (operatingModeSelect[0])
            state <= ST_RESET;
        ST_NORMAL:
          // Graceful requests wait for the frame on the wire
          if (operatingModeSelect == `MODE_FORCE)
            state <= ST_RESET;
          else if (operatingModeSelect != `MODE_NORMAL && !txBusy)
            state <= (operatingModeSelect == `MODE_HALT) ?
              ST_HALT : ST_RESET;
          else if ((busOffEntryIrq &&
                    recoveryMode == `RECOV_HALT_ENTRY) ||
                   (autoRecover && recoveryMode == `RECOV_HALT_END))
            state <= ST_HALT;
        default:
          state <= ST_SLEEP;
      endcase
      // Bit timing
      sampleTick <= 1'b0;
      bitTick <= 1'b0;
      if (state == ST_SLEEP || tqTick)
        preCnt <= {PRE_W{1'b0}};
      else
        preCnt <= preCnt + {{(PRE_W-1){1'b0}}, 1'b1};
      if (tqTick) begin
        if (tqCnt == ts1q) begin
          sampledBit <= busLine;
          sampleTick <= 1'b1;
        end
        if (tqCnt == ts1q + ts2q) begin
          tqCnt <= 5'h00;
          bitTick <= 1'b1;
        end else
          tqCnt <= tqCnt + 5'h01;
      end
      // Transmit pin, quiet unless allowed to drive
      canTx <= (running && !busOff && !txSilent &&
        testMode != `TEST_INT_LOOP) ? txBitIn : 1'b1;
      // Timestamp
      if (swReset) begin
        tsDiv <= 3'h0;
        timestamp <= 16'h0000;
      end else if (bitTick) begin
        tsDiv <= tsDiv + 3'h1;
        if ((tsDiv & selMask) == selMask)
          timestamp <= timestamp + 16'h0001;
      end
      // Bus lock watch
      busLockIrq <= 1'b0;
      if (sampleTick) begin
        if (busLine)
          domRun <= 6'h00;
        else if (domRun != `LOCK_RUN) begin
          domRun <= domRun + 6'h01;
          busLockIrq <= running && (domRun == `LOCK_RUN - 6'h01);
        end
      end
      // Transmit launch and completion
      txStart <= 1'b0;
      txFifoIrq <= 1'b0;
      if (swReset)
        txActive <= 1'b0;
      else if (!txActive && running && !busOff && !txSilent &&
               !txBusy && txFound && !txStart) begin
        txActive <= 1'b1;
        txStart <= 1'b1;
        txSlot <= txPick;
        if (txPick == `FIFO_SLOT) begin
          txIdOut <= txHead[ID_W-1:0];
          txIdeOut <= txHead[ID_W];
        end else begin
          txIdOut <= mailboxId[txPick*ID_W +: ID_W];
          txIdeOut <= mbExt[txPick[4:0]];
        end
      end else if (txOk || txFail)
        txActive <= 1'b0;
      // Transmit FIFO: a head is dropped only on success, failures retry
      if (swReset) begin
        txFifoCount <= 3'h0;
        txRd <= 2'h0;
        txWr <= 2'h0;
      end else begin
        if (txFifoPush && txFifoCount != `FIFO_DEPTH) begin
          txFifoMem[txWr] <= {txFifoIde, txFifoId};
          txWr <= txWr + 2'h1;
        end
        if (txActive && txSlot == `FIFO_SLOT && txOk) begin
          txRd <= txRd + 2'h1;
          txFifoIrq <= 1'b1;
        end
        txFifoCount <= txFifoCount +
          {2'b00, txFifoPush && txFifoCount != `FIFO_DEPTH} -
          {2'b00, txActive && txSlot == `FIFO_SLOT && txOk};
      end
      // Receive hand-off and FIFO
      rxStore <= 1'b0;
      rxOverrunIrq <= 1'b0;
      rxFifoIrq <= 1'b0;
      rxFifoHeadId <= rxFifoMem[rxRd];
      if (rxEvent && rxFound) begin
        rxStore <= overwriteMode || !newData[rxPick[4:0]];
        rxStoreSlot <= rxPick;
        rxOverrunIrq <= newData[rxPick[4:0]] && !overwriteMode;
      end
      if (swReset) begin
        rxFifoCount <= 3'h0;
        rxRd <= 2'h0;
        rxWr <= 2'h0;
      end else begin
        if (fifoTake && rxFifoCount != `FIFO_DEPTH) begin
          rxFifoMem[rxWr] <= rxFrameId;
          rxWr <= rxWr + 2'h1;
          rxFifoIrq <= 1'b1;
        end else if (fifoTake)
          rxOverrunIrq <= 1'b1;
        if (rxFifoPop && rxFifoCount != 3'h0)
          rxRd <= rxRd + 2'h1;
        rxFifoCount <= rxFifoCount +
          {2'b00, fifoTake && rxFifoCount != `FIFO_DEPTH} -
          {2'b00, rxFifoPop && rxFifoCount != 3'h0};
      end
      // Error code store, a new error beats a clear
      busErrorIrq <= 1'b0;
      if (swReset)
        errorCodeStore <= 3'h0;
      else if (running && (txBusError || rxBusError)) begin
        errorCodeStore <= (errorCodeClear ? 3'h0 : errorCodeStore) |
          busErrorType;
        busErrorIrq <= 1'b1;
      end else if (errorCodeClear)
        errorCodeStore <= 3'h0;
      // Error counters and fault confinement
      errorWarningIrq <= 1'b0;
      errorPassiveIrq <= 1'b0;
      busOffEntryIrq <= 1'b0;
      busOffRecoveryIrq <= 1'b0;
      if (swReset || autoRecover || manualRecover) begin
        txErrorCount <= 9'h000;
        rxErrorCount <= 8'h00;
        errorPassive <= 1'b0;
        busOff <= 1'b0;
        recRun <= 4'h0;
        recRuns <= 8'h00;
        busOffRecoveryIrq <= autoRecover && !swReset;
      end else if (busOff) begin
        // Count runs of eleven recessive bits while off the bus
        if (sampleTick) begin
          if (!busLine)
            recRun <= 4'h0;
          else if (recRun == `RECESSIVE_RUN - 4'h1) begin
            recRun <= 4'h0;
            if (recRuns != `RECOVERY_RUNS)
              recRuns <= recRuns + 8'h01;
          end else
            recRun <= recRun + 4'h1;
        end
      end else if (running) begin
        // Counter wraps past 511 are impossible: bus-off stops counting
        txErrorCount <= next_tec;
        rxErrorCount <= next_rec;
        errorPassive <= nextPass;
        errorWarningIrq <= nextWarn && !curWarn;
        errorPassiveIrq <= nextPass && !errorPassive;
        if (next_tec >= `ERR_BUS_OFF) begin
          busOff <= 1'b1;
          busOffEntryIrq <= 1'b1;
        end
      end
    end
  end

endmodule // can_mailbox_controller

/* File: shared/can_mailbox_regs.vh */
`ifndef CAN_MAILBOX_REGS_VH
`define CAN_MAILBOX_REGS_VH

// Operating mode select codes
`define MODE_NORMAL 2'h0
`define MODE_RESET 2'h1
`define MODE_HALT 2'h2
`define MODE_FORCE 2'h3

// Identifier format select codes
`define ID_FORMAT_MODE_SELECT_STD 2'h0
`define ID_FORMAT_MODE_SELECT_EXT 2'h1
`define ID_FORMAT_MODE_SELECT_MIX 2'h2

// Test mode codes
`define TEST_OFF 2'h0
`define TEST_LISTEN 2'h1
`define TEST_EXT_LOOP 2'h2
`define TEST_INT_LOOP 2'h3

// Bus-off recovery options
`define RECOV_AUTO 2'h0
`define RECOV_HALT_ENTRY 2'h1
`define RECOV_HALT_END 2'h2
`define RECOV_MANUAL 2'h3

// Error count thresholds and steps
`define ERR_WARN 9'h060
`define ERR_PASSIVE 9'h080
`define ERR_BUS_OFF 9'h100
`define TEC_STEP 9'h008
`define REC_MAX 8'hFF

// Bus monitor counts
`define RECESSIVE_RUN 4'hB
`define RECOVERY_RUNS 8'h80
`define LOCK_RUN 6'h20

// Bit timing minimum codes
`define TS1_MIN 4'h3
`define TS2_MIN 3'h1

// Mailbox layout
`define MB_COUNT 32
`define MB_NORMAL 24
`define FIFO_DEPTH 3'h4
`define FIFO_SLOT 6'h20
`define STD_SHIFT 18

`endif

/* File: sim/can_mailbox_controller_properties.sv */
`timescale 1ns/1ns
module can_mailbox_controller_properties (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Watched outputs
  input wire txStart,
  input wire [5:0] txSlot,
  input wire [31:0] txPending,
  input wire [31:0] abortComplete,
  input wire [31:0] messageLost,
  input wire [8:0] txErrorCount,
  input wire [7:0] rxErrorCount,
  input wire busOff,
  input wire sampledBit,
  input wire sleepState,
  input wire resetState,
  input wire haltState,
  input wire errorWarningIrq,
  input wire errorPassiveIrq,
  input wire busOffEntryIrq,
  input wire busOffRecoveryIrq,
  input wire busLockIrq,
  input wire rxOverrunIrq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_reset_sleep: assert property ($fell(rst) |-> sleepState)
    else $error("not in sleep after reset");
  a_sleep_exit: assert property (
    $fell(sleepState) |-> resetState || haltState)
    else $error("sleep left to a wrong mode");
  a_start_pending: assert property (
    txStart && !txSlot[5] |-> txPending[txSlot[4:0]])
    else $error("start without pending mailbox");
  a_abort_clears: assert property (
    ((abortComplete & ~$past(abortComplete)) & txPending) == 32'h0)
    else $error("abort left mailbox pending");
  a_warn_count: assert property (
    errorWarningIrq |-> txErrorCount >= 9'h060 || rxErrorCount >= 8'h60)
    else $error("warning below count");
  a_passive_count: assert property (
    errorPassiveIrq |-> txErrorCount >= 9'h080 || rxErrorCount >= 8'h80)
    else $error("passive below count");
  a_busoff_entry: assert property (
    busOffEntryIrq |-> ##[0:1] busOff && txErrorCount >= 9'h100)
    else $error("entry without bus-off");
  a_recovery_clear: assert property (
    busOffRecoveryIrq |-> ##[0:1] !busOff && txErrorCount == 9'h000)
    else $error("recovery left counts");
  a_lock_dominant: assert property (busLockIrq |-> !$past(sampledBit))
    else $error("lock on recessive bus");
  a_overrun_lost: assert property (
    rxOverrunIrq |-> messageLost != 32'h0)
    else $error("overrun without lost flag");
endmodule // can_mailbox_controller_properties
bind can_mailbox_controller can_mailbox_controller_properties
  can_mailbox_controller_properties_i (.*);

/* File: sim/can_bus_node.sv */
`timescale 1ns/1ns
module can_bus_node (
  // Bus lines
  input wire canTx,
  input wire holdDominant,
  output wire canRx
);
  // Wired-AND bus, recessive unless a node pulls it
  assign canRx = canTx & ~holdDominant;
endmodule // can_bus_node

/* File: sim/tb_can_mailbox_controller.sv */
`timescale 1ns/1ns
module tb_can_mailbox_controller;
  reg clk = 1'h0, rst = 1'h1, sleepRequest = 1'h1, txPriorityMode = 1'h1;
  reg fifoMailboxMode = 1'h0, overwriteMode = 1'h0, recoveryCommand = 1'h0;
  reg errorCodeClear = 1'h0, fifoIdCompareZeroRtr = 1'h0, holdDominant = 1'h0;
  reg fifoIdCompareOneRtr = 1'h0, txFifoPush = 1'h0, txFifoIde = 1'h0;
  reg rxFifoPop = 1'h0, rxFrameValid = 1'h0, rxFrameIde = 1'h1;
  reg rxFrameRtr = 1'h0, txFrameDone = 1'h0, txArbLost = 1'h0, txBitIn = 1'h1;
  reg txBusError = 1'h0, rxBusError = 1'h0, txBusy = 1'h0;
  reg [1:0] operatingModeSelect = 2'h1, idFormatModeSelect = 2'h1;
  reg [1:0] recoveryMode = 2'h0, testMode = 2'h0, timestampSelect = 2'h0;
  reg [9:0] prescalerSetting = 10'h000;
  reg [3:0] phaseSegmentOne = 4'h3;
  reg [2:0] phaseSegmentTwo = 3'h1, busErrorType = 3'h1;
  reg [31:0] txRequest = 32'h0, rxRequest = 32'h0, abortRequest = 32'h0;
  reg [31:0] oneShot = 32'h0, remoteRequestSelect = 32'h0, readAck = 32'h0;
  reg [31:0] frameIdLengthFlag = 32'h0, maskInvalidSelect = 32'hFFFFFFFF;
  reg [32*29-1:0] mailboxId = 928'h0;
  reg [8*29-1:0] acceptanceMask = 232'h0;
  reg [28:0] txFifoId = 29'h0, rxFrameId = 29'h0;
  reg [31:0] seed = 32'h792A72F4;
  wire canRx, canTx, sampledBit, sampleTick, bitTick, txStart, txIdeOut;
  wire rxStore, errorPassive, busOff, errorWarningIrq, errorPassiveIrq;
  wire busOffEntryIrq, busOffRecoveryIrq, busLockIrq, busErrorIrq;
  wire rxOverrunIrq, txFifoIrq, rxFifoIrq, sleepState, resetState, haltState;
  wire [5:0] txSlot, rxStoreSlot;
  wire [28:0] txIdOut, rxFifoHeadId;
  wire [31:0] txPending, sentData, abortComplete, newData, messageLost;
  wire [8:0] txErrorCount;
  wire [7:0] rxErrorCount;
  wire [2:0] errorCodeStore, txFifoCount, rxFifoCount;
  wire [15:0] timestamp;
  integer n_errors = 0, tests_run = 0, tx_error_counter = 0, i = 0, nBit = 0, nWarn = 0;
  integer nPass = 0, nEntry = 0, nRecov = 0, nLock = 0, nOver = 0, nStart = 0;
  can_mailbox_controller can_mailbox_controller_i (.*);
  can_bus_node can_bus_node_i (.canTx(canTx), .holdDominant(holdDominant),
    .canRx(canRx));
  always #10 clk = ~clk;
  // Pulses are one cycle wide, so they are counted rather than sampled
  always @(posedge clk) begin
    nBit <= nBit + bitTick;
    nWarn <= nWarn + errorWarningIrq;
    nPass <= nPass + errorPassiveIrq;
    nEntry <= nEntry + busOffEntryIrq;
    nRecov <= nRecov + busOffRecoveryIrq;
    nLock <= nLock + busLockIrq;
    nOver <= nOver + rxOverrunIrq;
    nStart <= nStart + txStart;
  end
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task tick(input integer n);
    repeat (n) @(negedge clk);
  endtask
  task chk(input [127:0] got, input [127:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  // Engine event pulse: rx error, tx error, lost, done
  task ev(input [3:0] v);
    begin
      {rxBusError, txBusError, txArbLost, txFrameDone} = v;
      tick(1);
      {rxBusError, txBusError, txArbLost, txFrameDone} = 4'h0;
    end
  endtask
  task frame(input [28:0] id);
    begin
      tick(1);
      rxFrameId = id;
      rxFrameValid = 1'h1;
      tick(1);
      rxFrameValid = 1'h0;
    end
  endtask
  task finish_test;
    begin
      $display("checks %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  initial begin
    #1000000;
    n_errors = n_errors + 1;
    finish_test;
  end
  initial begin
    tick(20);
    rst = 1'h0;
    chk(sleepState, 1);
    sleepRequest = 1'h0;
    tick(2);
    chk({resetState, sleepState}, 2'h2);
    operatingModeSelect = 2'h0;
    tick(3);
    chk(resetState, 0);
    i = nBit;
    tx_error_counter = timestamp;
    tick(700);
    chk(nBit - i, 100);
    chk(timestamp - tx_error_counter, 100);
    $display("mode and timing done");
    txRequest = 32'h24;
    tick(1);
    txRequest = 32'h0;
    tick(1);
    chk({txStart, txSlot}, 7'h42);
    tick(2);
    ev(4'h1);
    tick(1);
    chk({sentData[2], txPending}, 33'h1_0000_0020);
    tick(2);
    txRequest = 32'h200;
    tick(1);
    abortRequest = 32'h200;
    txRequest = 32'h0;
    tick(1);
    abortRequest = 32'h0;
    tick(1);
    chk({abortComplete[9], txPending[9]}, 2'h2);
    i = nStart;
    ev(4'h2);
    tick(4);
    chk(nStart - i, 1);
    oneShot = 32'h20;
    ev(4'h4);
    tx_error_counter = 8;
    tick(4);
    chk({txPending, txErrorCount}, tx_error_counter);
    $display("transmit done");
    seed = lfsr(seed);
    mailboxId[29 +: 29] = seed[28:0];
    rxRequest = 32'h2;
    tick(1);
    rxRequest = 32'h0;
    tick(1);
    frame(seed[28:0] ^ 29'h1);
    chk(newData, 0);
    frame(seed[28:0]);
    chk({newData[1], rxStore, rxStoreSlot}, 8'hC1);
    frame(seed[28:0]);
    tick(1);
    chk({messageLost[1], nOver}, 33'h1_0000_0001);
    holdDominant = 1'h1;
    tick(300);
    holdDominant = 1'h0;
    chk(nLock, 1);
    $display("receive and lock done");
    // A retrying mailbox keeps a transmit active for every error
    txRequest = 32'h8;
    tick(1);
    txRequest = 32'h0;
    tick(1);
    while (tx_error_counter < 256) begin
      ev(4'h4);
      tx_error_counter = tx_error_counter + 8;
      tick(1);
      chk(txErrorCount, tx_error_counter);
    end
    tick(2);
    chk({busOff, nWarn, nPass, nEntry},
      97'h1_0000_0001_0000_0001_0000_0001);
    for (i = 0; i < 11000 && nRecov == 0; i = i + 1)
      tick(1);
    tick(2);
    chk({nRecov, busOff, txErrorCount}, 42'h400);
    operatingModeSelect = 2'h1;
    tick(3);
    chk({sentData, messageLost}, 64'h0);
    $display("error handling done");
    finish_test;
  end
endmodule // tb_can_mailbox_controller
